// file: rtl/dspwm_pkg.sv
// Package for the dual-slope symmetric PWM timer.
// Shared by the top module and its two leaf modules; no clock of its own.
package dspwm_pkg;

  // ==========================================================================
  // Register map (byte addresses, 32-bit aligned words)
  localparam logic [11:0] ADDR_CONTROL_A  = 12'h080;
  localparam logic [11:0] ADDR_CONTROL_B  = 12'h084;
  localparam logic [11:0] ADDR_COMPARE_A  = 12'h088;
  localparam logic [11:0] ADDR_COMPARE_B  = 12'h08c;
  localparam logic [11:0] ADDR_CAPTURE    = 12'h090;
  localparam logic [11:0] ADDR_COUNT      = 12'h094;
  localparam logic [11:0] ADDR_FLAGS      = 12'h098;
  localparam logic [11:0] ADDR_DIRECTION  = 12'h09c;

  // ==========================================================================
  // Field positions and reset values
  localparam int          CTLA_COMA_LSB   = 6;
  localparam int          CTLA_COMB_LSB   = 4;
  localparam int          CTLA_WGM_LSB    = 0;
  localparam int          CTLB_WGMHI_LSB  = 3;
  localparam int          CTLB_CS_LSB     = 0;
  localparam logic [7:0]  CTLA_RESET      = 8'h00;
  localparam logic [7:0]  CTLA_WMASK      = 8'hf3;
  localparam logic [7:0]  CTLB_RESET      = 8'h00;
  localparam logic [7:0]  CTLB_WMASK      = 8'h1f;
  localparam logic [15:0] REG16_RESET     = 16'h0000;
  localparam int          FLAG_OVF        = 0;
  localparam int          FLAG_MATCH_A    = 1;
  localparam int          FLAG_MATCH_B    = 2;
  localparam int          FLAG_CAPTURE    = 3;

  // ==========================================================================
  // Encodings
  localparam logic [3:0]  WGM_PFC_CAPTURE = 4'h8;
  localparam logic [3:0]  WGM_PFC_COMPARE = 4'h9;
  localparam logic [1:0]  COM_OFF         = 2'h0;
  localparam logic [1:0]  COM_TOGGLE      = 2'h1;
  localparam logic [1:0]  COM_NONINV      = 2'h2;
  localparam logic [1:0]  COM_INV         = 2'h3;
  localparam logic [15:0] BOTTOM          = 16'h0000;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam logic [1:0]  AXI_SLVERR      = 2'h2;

  // Prescaler divide counts (N-1)
  localparam logic [9:0]  DIV_8           = 10'h007;
  localparam logic [9:0]  DIV_64          = 10'h03f;
  localparam logic [9:0]  DIV_256         = 10'h0ff;
  localparam logic [9:0]  DIV_1024        = 10'h3ff;

  typedef enum logic [2:0] {
    DSPWM_CS_STOP,
    DSPWM_CS_1,
    DSPWM_CS_8,
    DSPWM_CS_64,
    DSPWM_CS_256,
    DSPWM_CS_1024
  } dspwm_cs_t;

  // Per-channel compare event carried to the output unit
  typedef struct packed {
    logic       tick;
    logic       match;
    logic       counting_up;
    logic       at_bottom;
    logic [1:0] mode;
    logic       toggle_ok;
  } dspwm_cmp_t;

endpackage

// file: rtl/dspwm_prescale.sv
// Prescaler producing the timer tick strobe from the I/O clock.
// Assumes aclk is the I/O clock; select comes from control register B.
`timescale 1ns/10ps
module dspwm_prescale
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire dspwm_pkg::dspwm_cs_t select,
  output logic                     tick
);

  logic [9:0] div_r;
  logic [9:0] limit;

  // ==========================================================================
  // Divide select
  always_comb
  begin
    case (select)
      dspwm_pkg::DSPWM_CS_8:    limit = dspwm_pkg::DIV_8;
      dspwm_pkg::DSPWM_CS_64:   limit = dspwm_pkg::DIV_64;
      dspwm_pkg::DSPWM_CS_256:  limit = dspwm_pkg::DIV_256;
      dspwm_pkg::DSPWM_CS_1024: limit = dspwm_pkg::DIV_1024;
      default:                  limit = 10'h000;
    endcase
  end

  // Strobe only, never a derived clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || select == dspwm_pkg::DSPWM_CS_STOP)
      div_r <= 10'h000;
    else if (div_r >= limit)
      div_r <= 10'h000;
    else
      div_r <= div_r + 10'h001;
  end

  assign tick = (select != dspwm_pkg::DSPWM_CS_STOP) && (div_r >= limit);

endmodule

// file: rtl/dspwm_wave.sv
// One compare output unit: waveform register for one channel.
// Assumes events arrive from the counter in the top module.
`timescale 1ns/10ps
module dspwm_wave
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire dspwm_pkg::dspwm_cmp_t ev,
  output logic                       wave
);

  logic up_eff;

  // Bottom counts as rising and top as falling, so a compare at either end holds the pin steady
  assign up_eff = ev.counting_up || ev.at_bottom;

  // ==========================================================================
  // Waveform register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wave <= 1'b0;
    else if (ev.tick && ev.match)
    begin
      case (ev.mode)
        dspwm_pkg::COM_NONINV: wave <= !up_eff;
        dspwm_pkg::COM_INV:    wave <= up_eff;
        dspwm_pkg::COM_TOGGLE: wave <= ev.toggle_ok ? !wave : wave;
        default:               wave <= wave;
      endcase
    end
  end

endmodule

// file: rtl/dspwm_top.sv
// Dual-slope symmetric PWM timer: counter, double-buffered compares, flags,
// two waveform pins and an AXI4-Lite register slave.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
//
// Behaviour
// - Modes 8 and 9 select symmetric PWM
// - Count zero to top, back to zero
// - Clear on up match, set down match
// - Mode two non-inverted, three inverted
// - Top from capture (8) or compare A (9)
// - Top held for one tick
// - Match flag set on compare equality
// - Overflow flag set at bottom reload
// - Top flag is match A or capture
// - Compares reload from buffers at bottom
// - Pin driven only when direction output
// - Bottom compare low, top compare high
// - Mode 9 toggle gives 50% duty; here on pin A only, B toggle code disconnects the pin
// - Prescaler 1, 8, 64, 256, 1024
// - Fully synchronous, tick is enable
// - Control A field layout, resets zero
// - Mode zero disconnects the pin
// - High mode bits in control B
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module dspwm_top
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  port_data,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe
);

  logic [7:0]  ctla_r;
  logic [7:0]  ctlb_r;
  logic [15:0] buf_a_r;
  logic [15:0] buf_b_r;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [15:0] capture_r;
  logic [15:0] count_r;
  logic        up_r;
  logic [3:0]  flags_r;
  logic [1:0]  dir_r;
  logic [11:0] awaddr_r;
  logic        aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_held_r;
  logic [1:0]  waves;
  logic        tick;
  logic [3:0]  wgm;
  logic        pfc_mode;
  logic [15:0] top;
  logic        at_top;
  logic        at_bottom;
  logic        do_write;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  dspwm_pkg::dspwm_cmp_t ev_a;
  dspwm_pkg::dspwm_cmp_t ev_b;

  // ==========================================================================
  // Mode decode
  assign wgm = {ctlb_r[dspwm_pkg::CTLB_WGMHI_LSB +: 2], ctla_r[dspwm_pkg::CTLA_WGM_LSB +: 2]};
  assign pfc_mode = (wgm == dspwm_pkg::WGM_PFC_CAPTURE) || (wgm == dspwm_pkg::WGM_PFC_COMPARE);
  assign top = (wgm == dspwm_pkg::WGM_PFC_COMPARE) ? cmp_a_r : capture_r;
  assign at_top = (count_r == top);
  assign at_bottom = (count_r == dspwm_pkg::BOTTOM);

  dspwm_prescale u_prescale
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .select  (dspwm_pkg::dspwm_cs_t'(ctlb_r[dspwm_pkg::CTLB_CS_LSB +: 3])),
    .tick    (tick)
  );

  // ==========================================================================
  // Counter: every value, top and bottom included, lasts one tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= dspwm_pkg::REG16_RESET;
    else if (do_write && awaddr_r == dspwm_pkg::ADDR_COUNT)
      count_r <= wdata_r[15:0];
    else if (tick && pfc_mode)
    begin
      if (up_r && !at_top)
        count_r <= count_r + 16'h0001;
      else if (up_r)
        count_r <= count_r - 16'h0001;
      else if (!at_bottom)
        count_r <= count_r - 16'h0001;
      else
        count_r <= count_r + 16'h0001;
    end
  end

  // Direction reverses on the tick that leaves top or bottom
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      up_r <= 1'b1;
    else if (tick && pfc_mode)
    begin
      if (up_r && at_top)
        up_r <= 1'b0;
      else if (!up_r && at_bottom)
        up_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Double-buffered compares: write goes to buffer, reload at bottom
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_a_r <= dspwm_pkg::REG16_RESET;
      cmp_b_r <= dspwm_pkg::REG16_RESET;
    end
    else if (!pfc_mode)
    begin
      cmp_a_r <= buf_a_r;
      cmp_b_r <= buf_b_r;
    end
    else if (tick && at_bottom)
    begin
      cmp_a_r <= buf_a_r;
      cmp_b_r <= buf_b_r;
    end
  end

  // ==========================================================================
  // Flags: set wins over a same-cycle write-one-to-clear
  always_comb
  begin
    flag_set = 4'h0;
    if (tick && pfc_mode)
    begin
      flag_set[dspwm_pkg::FLAG_OVF]     = at_bottom;
      flag_set[dspwm_pkg::FLAG_MATCH_A] = (count_r == cmp_a_r);
      flag_set[dspwm_pkg::FLAG_MATCH_B] = (count_r == cmp_b_r);
      flag_set[dspwm_pkg::FLAG_CAPTURE] = at_top && (wgm == dspwm_pkg::WGM_PFC_CAPTURE);
    end
  end

  assign flag_clr = (do_write && awaddr_r == dspwm_pkg::ADDR_FLAGS && wstrb_r[0]) ? wdata_r[3:0] : 4'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= 4'h0;
    else
      flags_r <= (flags_r & ~flag_clr) | flag_set;
  end

  // ==========================================================================
  // Output compare units
  assign ev_a = '{tick: tick && pfc_mode, match: count_r == cmp_a_r, counting_up: up_r && !at_top,
                  at_bottom: at_bottom, mode: ctla_r[dspwm_pkg::CTLA_COMA_LSB +: 2],
                  toggle_ok: wgm == dspwm_pkg::WGM_PFC_COMPARE};
  assign ev_b = '{tick: tick && pfc_mode, match: count_r == cmp_b_r, counting_up: up_r && !at_top,
                  at_bottom: at_bottom, mode: ctla_r[dspwm_pkg::CTLA_COMB_LSB +: 2],
                  toggle_ok: 1'b0};

  dspwm_wave u_wave_a
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ev      (ev_a),
    .wave    (waves[0])
  );

  dspwm_wave u_wave_b
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ev      (ev_b),
    .wave    (waves[1])
  );

  // Pin mux: compare unit overrides port data unless disconnected
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= 2'h0;
      pin_oe  <= 2'h0;
    end
    else
    begin
      pin_oe <= dir_r;
      pin_out[0] <= (ctla_r[dspwm_pkg::CTLA_COMA_LSB +: 2] == dspwm_pkg::COM_OFF) ? port_data[0] : waves[0];
      // Channel B toggle code is disconnected as well
      pin_out[1] <= (ctla_r[dspwm_pkg::CTLA_COMB_LSB +: 2] inside {dspwm_pkg::COM_OFF, dspwm_pkg::COM_TOGGLE})
                    ? port_data[1] : waves[1];
    end
  end

  // ==========================================================================
  // AXI4-Lite write: address and data held independently
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 12'h000;
    end
    else if (do_write)
      aw_held_r <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end
    else if (do_write)
      w_held_r <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end
  end

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

  assign wr_hit = awaddr_r inside {dspwm_pkg::ADDR_CONTROL_A, dspwm_pkg::ADDR_CONTROL_B,
                  dspwm_pkg::ADDR_COMPARE_A, dspwm_pkg::ADDR_COMPARE_B, dspwm_pkg::ADDR_CAPTURE,
                  dspwm_pkg::ADDR_COUNT, dspwm_pkg::ADDR_FLAGS, dspwm_pkg::ADDR_DIRECTION};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dspwm_pkg::AXI_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? dspwm_pkg::AXI_OKAY : dspwm_pkg::AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register stores; compare buffers and capture honour two byte lanes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctla_r    <= dspwm_pkg::CTLA_RESET;
      ctlb_r    <= dspwm_pkg::CTLB_RESET;
      buf_a_r   <= dspwm_pkg::REG16_RESET;
      buf_b_r   <= dspwm_pkg::REG16_RESET;
      capture_r <= dspwm_pkg::REG16_RESET;
      dir_r     <= 2'h0;
    end
    else if (do_write)
    begin
      case (awaddr_r)
        dspwm_pkg::ADDR_CONTROL_A:
          if (wstrb_r[0]) ctla_r <= wdata_r[7:0] & dspwm_pkg::CTLA_WMASK;
        dspwm_pkg::ADDR_CONTROL_B:
          if (wstrb_r[0]) ctlb_r <= wdata_r[7:0] & dspwm_pkg::CTLB_WMASK;
        dspwm_pkg::ADDR_COMPARE_A:
        begin
          if (wstrb_r[0]) buf_a_r[7:0]  <= wdata_r[7:0];
          if (wstrb_r[1]) buf_a_r[15:8] <= wdata_r[15:8];
        end
        dspwm_pkg::ADDR_COMPARE_B:
        begin
          if (wstrb_r[0]) buf_b_r[7:0]  <= wdata_r[7:0];
          if (wstrb_r[1]) buf_b_r[15:8] <= wdata_r[15:8];
        end
        dspwm_pkg::ADDR_CAPTURE:
        begin
          if (wstrb_r[0]) capture_r[7:0]  <= wdata_r[7:0];
          if (wstrb_r[1]) capture_r[15:8] <= wdata_r[15:8];
        end
        dspwm_pkg::ADDR_DIRECTION:
          if (wstrb_r[0]) dir_r <= wdata_r[1:0];
        default:
          ctla_r <= ctla_r;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read: one-cycle answer after the address is taken
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      dspwm_pkg::ADDR_CONTROL_A: rd_word = {24'h000000, ctla_r};
      dspwm_pkg::ADDR_CONTROL_B: rd_word = {24'h000000, ctlb_r};
      dspwm_pkg::ADDR_COMPARE_A: rd_word = {16'h0000, buf_a_r};
      dspwm_pkg::ADDR_COMPARE_B: rd_word = {16'h0000, buf_b_r};
      dspwm_pkg::ADDR_CAPTURE:   rd_word = {16'h0000, capture_r};
      dspwm_pkg::ADDR_COUNT:     rd_word = {16'h0000, count_r};
      dspwm_pkg::ADDR_FLAGS:     rd_word = {27'h0000000, up_r, flags_r};
      dspwm_pkg::ADDR_DIRECTION: rd_word = {30'h00000000, dir_r};
      default:                   rd_hit  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dspwm_pkg::AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? dspwm_pkg::AXI_OKAY : dspwm_pkg::AXI_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// file: tb/dspwm_sva.sv
// Checker for the dual-slope PWM timer: bus handshakes and pin enables.
// Sees only ports of dspwm_top; bound to every instance of it below.
`timescale 1ns/10ps
module dspwm_sva
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  pin_oe
);
  logic [11:0] rd_addr_r;

  // ==========================================================================
  // Address of the read under way
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr_r <= s_axi_araddr;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Properties
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == dspwm_pkg::AXI_OKAY ||
                                s_axi_bresp == dspwm_pkg::AXI_SLVERR)
    else $error("write response code neither okay nor slave error");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                 |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  ctla_layout_a: assert property (s_axi_rvalid && rd_addr_r[11:2] == dspwm_pkg::ADDR_CONTROL_A[11:2]
                                  |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("control A read shows nonzero reserved bits");
  oe_cause_a: assert property (!$stable(pin_oe) |-> $past(s_axi_bvalid))
    else $error("pin enable changed without a register write");
endmodule

bind dspwm_top dspwm_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_oe(pin_oe));

// file: tb/dspwm_top_test.sv
// Self-checking bench for the dual-slope PWM timer.
// Drives the AXI4-Lite slave and port data itself; counts pin levels.
`timescale 1ns/10ps
module dspwm_top_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [1:0]  port_data = 2'h0;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  int          bad_count = 0;
  int          n_checks = 0;

  always #2.5 aclk = ~aclk;

  dspwm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_data(port_data), .pin_out(pin_out),
    .pin_oe(pin_oe));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge aclk);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string name);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge aclk);
    s_axi_rready <= 1'b0;
    check(name, e, s_axi_rdata & m);
    check("rresp", 32'h0, {30'h0, s_axi_rresp});
  endtask

  // Whole periods only, so the count does not depend on phase
  task automatic pin_hi(input int span, input int exp_a, input int exp_b);
    int hi_a;
    int hi_b;
    hi_a = 0;
    hi_b = 0;
    repeat (span)
    begin
      @(negedge aclk);
      hi_a += (pin_out[0] === 1'b1);
      hi_b += (pin_out[1] === 1'b1);
    end
    check("pin_a_high", exp_a, hi_a);
    check("pin_b_high", exp_b, hi_b);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      axi_rd(12'h080 + 12'(4 * i), (i == 6) ? 32'hf : 32'hffffffff, 32'h0, "reset_value");
    axi_wr(dspwm_pkg::ADDR_CONTROL_A, 32'hff, dspwm_pkg::AXI_OKAY);
    axi_rd(dspwm_pkg::ADDR_CONTROL_A, 32'hffffffff, 32'hf3, "control_a");
    axi_wr(12'h0a0, 32'h1, dspwm_pkg::AXI_SLVERR);
  endtask

  // Mode 8, top 4: A non-inverted compare 1, B inverted compare 0
  task automatic t_pwm;
    int divs[5] = '{1, 8, 64, 256, 1024};
    axi_wr(dspwm_pkg::ADDR_DIRECTION, 32'h3, dspwm_pkg::AXI_OKAY);
    repeat (2) @(negedge aclk);
    check("pin_oe", 32'h3, {30'h0, pin_oe});
    axi_wr(dspwm_pkg::ADDR_CAPTURE, 32'h4, dspwm_pkg::AXI_OKAY);
    axi_wr(dspwm_pkg::ADDR_COMPARE_A, 32'h1, dspwm_pkg::AXI_OKAY);
    axi_wr(dspwm_pkg::ADDR_COMPARE_B, 32'h0, dspwm_pkg::AXI_OKAY);
    axi_wr(dspwm_pkg::ADDR_CONTROL_A, 32'hb0, dspwm_pkg::AXI_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      axi_wr(dspwm_pkg::ADDR_CONTROL_B, 32'h11 + 32'(i), dspwm_pkg::AXI_OKAY);
      repeat (8 * divs[i] + 4) @(posedge aclk);
      pin_hi(16 * divs[i], 4 * divs[i], 16 * divs[i]);
    end
    axi_rd(dspwm_pkg::ADDR_FLAGS, 32'hf, 32'hf, "flags_set");
    axi_wr(dspwm_pkg::ADDR_CONTROL_B, 32'h10, dspwm_pkg::AXI_OKAY);
    axi_wr(dspwm_pkg::ADDR_FLAGS, 32'hf, dspwm_pkg::AXI_OKAY);
    axi_rd(dspwm_pkg::ADDR_FLAGS, 32'hf, 32'h0, "flags_clear");
  endtask

  // Mode 9, top 5 from compare A, A toggles, B back to port data
  task automatic t_toggle;
    @(posedge aclk);
    port_data <= 2'h2;
    axi_wr(dspwm_pkg::ADDR_CONTROL_A, 32'h41, dspwm_pkg::AXI_OKAY);
    axi_wr(dspwm_pkg::ADDR_COMPARE_A, 32'h5, dspwm_pkg::AXI_OKAY);
    // Restart from bottom: the stopped count may sit above the top in use, compare A of 1 until reload at bottom
    axi_wr(dspwm_pkg::ADDR_COUNT, 32'h0, dspwm_pkg::AXI_OKAY);
    axi_wr(dspwm_pkg::ADDR_CONTROL_B, 32'h11, dspwm_pkg::AXI_OKAY);
    repeat (40) @(posedge aclk);
    pin_hi(100, 50, 100);
    axi_rd(dspwm_pkg::ADDR_FLAGS, 32'ha, 32'h2, "flags_mode9");
    axi_wr(dspwm_pkg::ADDR_DIRECTION, 32'h0, dspwm_pkg::AXI_OKAY);
    repeat (2) @(negedge aclk);
    check("pin_oe", 32'h0, {30'h0, pin_oe});
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Sequence and watchdog
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pwm();
    t_toggle();
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule
